// ---- logic/adr_decode_defines.svh ----
// Address map constants for the first-level address decoder
`ifndef ADR_DECODE_DEFINES_SVH
`define ADR_DECODE_DEFINES_SVH

// ****************************************************************
// Bank split: sixteen 256-Mbyte banks on the top four bits
// ****************************************************************
`define ADR_BANK_HI       31
`define ADR_BANK_LO       28
`define ADR_BANK_INTERNAL 4'h0
`define ADR_BANK_EXT_BASE 4'h1
`define ADR_EXT_COUNT     6
`define ADR_BANK_DRAM     4'h7
`define ADR_BANK_PERIPH   4'hF

// ****************************************************************
// Second level inside bank 0: 1-Mbyte areas
// ****************************************************************
`define ADR_AREA_HI       27
`define ADR_AREA_LO       20
`define ADR_AREA_BOOT     8'h00
`define ADR_AREA_ICPL     8'h01
`define ADR_AREA_DCPL     8'h02
`define ADR_AREA_SHARED   8'h03
`define ADR_AREA_ROM      8'h04
`define ADR_WIN_HI        19

// ****************************************************************
// SRAM partition sizes in bytes and split codes
// ****************************************************************
`define ADR_SIZE_NONE     17'h00000
`define ADR_SIZE_HALF     17'h08000
`define ADR_SIZE_FULL     17'h10000
`define ADR_SPLIT_SHARED  2'h0
`define ADR_SPLIT_DATA    2'h1
`define ADR_SPLIT_HALVES  2'h2

`endif

// ---- logic/adr_pkg.sv ----
// Types shared by the address decoder modules
package adr_pkg;

    // Transfer sequencer states
    typedef enum logic [2:0] {
        ADR_IDLE,
        ADR_WAIT,
        ADR_RESP,
        ADR_ERR1,
        ADR_ERR2
    } adr_state_e;

    // Physical SRAM offset within the 64-Kbyte array
    typedef logic [15:0] adr_offset_t;

endpackage : adr_pkg

// ---- logic/adr_sel_if.sv ----
// Target selection bundle between region decode and the sequencer
`timescale 1ns/1ps
interface adr_sel_if;
    import adr_pkg::*;
    logic [5:0]  extCs;      // One per external chip select
    logic        dram;       // Dedicated DRAM chip select
    logic        periph;     // Peripheral bridge
    logic        rom;        // Internal ROM
    logic        sram;       // Internal SRAM port
    logic        coupled;    // Hit on a coupled partition
    logic        abort;      // No target
    logic [19:0] winOffset;  // Offset inside the 1-Mbyte window
    adr_offset_t sramOffset; // Physical SRAM offset

    // Decoder drives, sequencer samples
    modport producer (output extCs, dram, periph, rom, sram, coupled,
                      abort, winOffset, sramOffset);
    modport consumer (input extCs, dram, periph, rom, sram, coupled,
                      abort, winOffset, sramOffset);
endinterface : adr_sel_if

// ---- logic/adr_sram_part.sv ----
// SRAM partition decode: windows, aliases and physical offsets
`timescale 1ns/1ps
`include "adr_decode_defines.svh"
module adr_sram_part
    import adr_pkg::*;
(
    input  wire logic [31:0] addr,
    input  wire logic        remapOn,
    input  wire logic [1:0]  split,
    output logic             hit,
    output logic             coupled,
    output adr_offset_t      offset
);
    logic [16:0] iSize;   // Instruction partition bytes
    logic [16:0] dSize;   // Data partition bytes
    logic [16:0] cSize;   // Shared partition bytes
    logic [7:0]  area;    // 1-Mbyte area inside bank 0
    logic [16:0] low;     // Low window bits, one spare for compare
    logic        inBank0; // Top bits select internal bank

    assign area    = addr[`ADR_AREA_HI:`ADR_AREA_LO];
    assign inBank0 = addr[`ADR_BANK_HI:`ADR_BANK_LO] == `ADR_BANK_INTERNAL;
    assign low     = {1'b0, addr[15:0]};

    // Three legal splits; an illegal code falls back to all-shared
    always_comb begin
        iSize = `ADR_SIZE_NONE;
        dSize = `ADR_SIZE_NONE;
        cSize = `ADR_SIZE_NONE;
        unique case (split)
            `ADR_SPLIT_DATA: begin
                dSize = `ADR_SIZE_FULL;
            end
            `ADR_SPLIT_HALVES: begin
                iSize = `ADR_SIZE_HALF;
                dSize = `ADR_SIZE_HALF;
            end
            default: begin
                cSize = `ADR_SIZE_FULL;
            end
        endcase
    end

    // Window hit; the upper window bits must be clear to stay in size
    always_comb begin
        hit     = 1'b0;
        coupled = 1'b0;
        offset  = addr[15:0];
        if (inBank0 && addr[`ADR_WIN_HI:16] == 4'h0) begin
            if (area == `ADR_AREA_ICPL) begin
                hit     = low < iSize;
                coupled = 1'b1;
            end else if (area == `ADR_AREA_DCPL) begin
                hit     = low < dSize;
                coupled = 1'b1;
                offset  = addr[15:0] + iSize[15:0];      // Data after instr
            end else if (area == `ADR_AREA_SHARED) begin
                hit     = low < cSize;
            end else if (area == `ADR_AREA_BOOT && remapOn) begin
                hit     = low < cSize;
            end
        end
    end
endmodule : adr_sram_part

// ---- logic/adr_region_decode.sv ----
// First-level bank decode and boot window steering
`timescale 1ns/1ps
`include "adr_decode_defines.svh"
module adr_region_decode
    import adr_pkg::*;
(
    input  wire logic [31:0] addr,
    input  wire logic        remapOn,
    input  wire logic        bootRom,
    input  wire logic        sramHit,
    input  wire logic        sramCoupled,
    input  wire adr_offset_t sramOffset,
    adr_sel_if.producer      sel
);
    logic [3:0] bank;  // Top four address bits
    logic [7:0] area;  // Second-level area in bank 0
    logic       boot0; // Access falls in the boot window
    logic       romIn; // ROM decoded by either base

    assign bank  = addr[`ADR_BANK_HI:`ADR_BANK_LO];
    assign area  = addr[`ADR_AREA_HI:`ADR_AREA_LO];
    assign boot0 = bank == `ADR_BANK_INTERNAL && area == `ADR_AREA_BOOT;
    // ROM always at its base; at zero only before remap
    assign romIn = (bank == `ADR_BANK_INTERNAL && area == `ADR_AREA_ROM)
                 || (boot0 && !remapOn && bootRom);

    // One chip select per external bank, in bank order
    genvar i;
    generate
        for (i = 0; i < `ADR_EXT_COUNT; i++) begin : g_ext
            // Low boot level puts chip select zero at address zero
            if (i == 0) begin : g_cs0
                assign sel.extCs[i] = bank == `ADR_BANK_EXT_BASE
                    || (boot0 && !remapOn && !bootRom);
            end else begin : g_csn
                assign sel.extCs[i] =
                    bank == `ADR_BANK_EXT_BASE + 4'(i);
            end
        end
    endgenerate

    assign sel.dram       = bank == `ADR_BANK_DRAM;
    assign sel.periph     = bank == `ADR_BANK_PERIPH;
    assign sel.rom        = romIn;
    assign sel.sram       = sramHit;
    assign sel.coupled    = sramHit && sramCoupled;
    assign sel.winOffset  = addr[`ADR_WIN_HI:0];
    assign sel.sramOffset = sramOffset;
    // Nothing claimed it: unused bank or empty internal area
    assign sel.abort = !(|sel.extCs || sel.dram || sel.periph
                         || romIn || sramHit);
endmodule : adr_region_decode

// ---- logic/adr_decoder_top.sv ----
// Bus matrix first-level decoder with boot selection and remap
//
// What this block does
// - Top four bits pick sixteen 256-Mbyte banks
// - Banks one to six drive chip selects 0-5
// - Bank seven drives the DRAM chip select
// - Bank zero holds internal memories, 1-Mbyte areas
// - Bank fifteen reaches the peripheral bridge
// - Unassigned space reaches no target, aborts
// - SRAM is four 16-Kbyte blocks, one port
// - Before remap SRAM only at partition bases
// - After remap shared SRAM also decoded at zero
// - Wait bit adds one coupled-access wait state
// - Three selectable SRAM splits
// - Partitions at 0x100000, 0x200000, 0x300000
// - After remap shared partition also at zero
// - ROM always decoded at 0x00400000
// - High boot level maps ROM at zero
// - Boot level caught at reset; zero window reserved
// - Low boot level maps chip select zero
// - Every memory always reachable at own base
// - Boot memory in place from first fetch
// - External boot: byte-select, 16-bit, strobes by select
`timescale 1ns/1ps
`include "adr_decode_defines.svh"
module adr_decoder_top
    import adr_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        clkEn,
    input  wire logic        bootSelectPin,
    input  wire logic        remapCmd,
    input  wire logic        coupledMemWaitStateBit,
    input  wire logic [1:0]  sramSplit,
    input  wire logic        reqValid,
    input  wire logic [31:0] reqAddr,
    output logic             reqReady,
    output logic             respValid,
    output logic             respError,
    output logic [5:0]       extChipSelect,
    output logic             dramChipSelect,
    output logic             periphSelect,
    output logic             romSelect,
    output logic             sramSelect,
    output logic [19:0]      targetOffset,
    output logic [15:0]      sramOffset,
    output logic             remapActive,
    output logic             bootFromRom,
    output logic             smcByteSelect,
    output logic             smcBus16,
    output logic             smcStrobeByCs
);
    // ************************************************************
    // Declarations
    // ************************************************************
    // Boot and remap
    logic        bootSync1_reg;     // First synchroniser stage
    logic        bootSync2_reg;     // Second synchroniser stage
    logic        bootCaught_reg;    // Boot level has been latched
    logic        bootLevel_reg;     // Latched boot level
    logic        remap_reg;         // Remap has been commanded

    // Sequencer
    adr_state_e  state_reg;         // Sequencer state
    adr_state_e  state_next;        // Sequencer next state
    logic        take;              // Request accepted this cycle
    logic        sramHit;           // SRAM window hit
    logic        sramCpl;           // Address in a coupled partition window, hit or not
    adr_offset_t sramOff;           // Physical SRAM offset

    // Output flops
    logic        reqReady_reg;      // Ready to accept
    logic        respValid_reg;     // Completion strobe
    logic        respError_reg;     // Error response level
    logic [5:0]  extCs_reg;         // External chip selects
    logic        dramCs_reg;        // DRAM chip select
    logic        periph_reg;        // Peripheral bridge select
    logic        rom_reg;           // ROM select
    logic        sram_reg;          // SRAM port select
    logic [19:0] winOff_reg;        // Window offset
    logic [15:0] sramOff_reg;       // SRAM physical offset
    logic        smcMode_reg;       // External boot defaults applied

    adr_sel_if sel ();              // Decoder result bundle

    // ************************************************************
    // Decode stages
    // ************************************************************
    // Pure logic, flopped on accept
    // SRAM partitions; aliases only add, bases never move
    adr_sram_part u_sram (
        .addr    (reqAddr),
        .remapOn (remap_reg),
        .split   (sramSplit),
        .hit     (sramHit),
        .coupled (sramCpl),
        .offset  (sramOff)
    );

    // Bank level plus boot-window steering
    adr_region_decode u_region (
        .addr        (reqAddr),
        .remapOn     (remap_reg),
        .bootRom     (bootLevel_reg),
        .sramHit     (sramHit),
        .sramCoupled (sramCpl),
        .sramOffset  (sramOff),
        .sel         (sel.producer)
    );

    // ************************************************************
    // Boot level capture
    // ************************************************************
    // Pin is asynchronous: two flops, only the second stage reads the first
    // No reset: chain runs during reset
    always_ff @(posedge mclk) begin
        if (clkEn) begin
            bootSync1_reg <= bootSelectPin;
            bootSync2_reg <= bootSync1_reg;
        end
    end

    // Latched once just after reset release, then frozen
    // Held through the whole run so a pin change has no effect
    always_ff @(posedge mclk) begin
        if (rst) begin
            bootCaught_reg <= 1'b0;
            bootLevel_reg  <= 1'b0;
        end else if (clkEn && !bootCaught_reg) begin
            bootCaught_reg <= 1'b1;
            bootLevel_reg  <= bootSync2_reg;
        end
    end

    // Static controller boot defaults follow a low boot level
    // Fixed until reset; software reprograms the controller itself
    always_ff @(posedge mclk) begin
        if (rst) begin
            smcMode_reg <= 1'b0;
        end else if (clkEn && !bootCaught_reg) begin
            smcMode_reg <= !bootSync2_reg;
        end
    end

    // ************************************************************
    // Remap state
    // ************************************************************
    // Sticky: only reset clears it, a second command is harmless
    // Software is trusted to issue it only once booted
    // Dropped while frozen
    always_ff @(posedge mclk) begin
        if (rst) begin
            remap_reg <= 1'b0;
        end else if (clkEn && remapCmd && bootCaught_reg) begin
            remap_reg <= 1'b1;
        end
    end

    // ************************************************************
    // Transfer sequencer
    // ************************************************************
    // No request is taken before the boot level is known, so the
    // very first fetch at zero already sees the boot memory
    assign take = reqValid && reqReady_reg;

    // Next state from decode outcome
    // Abort skips any wait state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ADR_IDLE: begin
                if (take) begin
                    if (sel.abort) begin
                        state_next = ADR_ERR1;
                    end else if (sel.coupled
                                 && coupledMemWaitStateBit) begin
                        state_next = ADR_WAIT;
                    end else begin
                        state_next = ADR_RESP;
                    end
                end
            end
            ADR_WAIT: begin
                state_next = ADR_RESP;                  // One extra cycle
            end
            ADR_RESP: begin
                state_next = ADR_IDLE;
            end
            ADR_ERR1: begin
                state_next = ADR_ERR2;
            end
            ADR_ERR2: begin
                state_next = ADR_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= ADR_IDLE;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

    // Ready only in idle with the boot level known
    // reqReady is the only refusal sign
    always_ff @(posedge mclk) begin
        if (rst) begin
            reqReady_reg <= 1'b0;
        end else if (clkEn) begin
            reqReady_reg <= bootCaught_reg
                            && state_next == ADR_IDLE;
        end
    end

    // Completion and error strobes
    // Error stands two cycles; completion rises on the second
    always_ff @(posedge mclk) begin
        if (rst) begin
            respValid_reg <= 1'b0;
            respError_reg <= 1'b0;
        end else if (clkEn) begin
            respValid_reg <= state_next == ADR_RESP
                             || state_next == ADR_ERR2;
            respError_reg <= state_next == ADR_ERR1
                             || state_next == ADR_ERR2;
        end
    end

    // ************************************************************
    // Target selects
    // ************************************************************
    // Loaded on accept, held to the end of the response, dropped
    // in idle; an abort loads nothing so no target ever sees it
    always_ff @(posedge mclk) begin
        if (rst) begin
            extCs_reg  <= 6'h00;
            dramCs_reg <= 1'b0;
            periph_reg <= 1'b0;
            rom_reg    <= 1'b0;
            sram_reg   <= 1'b0;
        end else if (clkEn) begin
            if (take && !sel.abort) begin
                extCs_reg  <= sel.extCs;
                dramCs_reg <= sel.dram;
                periph_reg <= sel.periph;
                rom_reg    <= sel.rom;
                sram_reg   <= sel.sram;
            end else if (state_next == ADR_IDLE
                         || state_next == ADR_ERR1) begin
                extCs_reg  <= 6'h00;
                dramCs_reg <= 1'b0;
                periph_reg <= 1'b0;
                rom_reg    <= 1'b0;
                sram_reg   <= 1'b0;
            end
        end
    end

    // Offsets load on every accept, aborts too; unchanged between accesses
    always_ff @(posedge mclk) begin
        if (rst) begin
            winOff_reg  <= 20'h00000;
            sramOff_reg <= 16'h0000;
        end else if (clkEn && take) begin
            winOff_reg  <= sel.winOffset;
            sramOff_reg <= sel.sramOffset;
        end
    end

    // ************************************************************
    // Outputs, all straight from flops
    // ************************************************************
    // Handshake
    assign reqReady       = reqReady_reg;
    assign respValid      = respValid_reg;
    assign respError      = respError_reg;

    // Selects and offsets
    assign extChipSelect  = extCs_reg;
    assign dramChipSelect = dramCs_reg;
    assign periphSelect   = periph_reg;
    assign romSelect      = rom_reg;
    assign sramSelect     = sram_reg;
    assign targetOffset   = winOff_reg;
    assign sramOffset     = sramOff_reg;

    // Status
    assign remapActive    = remap_reg;
    assign bootFromRom    = bootLevel_reg;

    // One flop, three defaults
    assign smcByteSelect  = smcMode_reg;
    assign smcBus16       = smcMode_reg;
    assign smcStrobeByCs  = smcMode_reg;
endmodule : adr_decoder_top

// ---- sim/adr_master_model.sv ----
// Bus master model issuing single-word requests to the decoder
`timescale 1ns/1ps
module adr_master_model (
    input  wire logic        mclk,
    input  wire logic        reqReady,
    input  wire logic        respValid,
    input  wire logic        respError,
    output logic             reqValid,
    output logic [31:0]      reqAddr
);
    // Idle until the first request
    initial begin
        reqValid = 1'b0;
        reqAddr  = 32'h0;
    end
    // Request held until taken; address inverted once released
    task automatic access(input logic [31:0] a, output int lat,
                          output logic err);
        int n;
        n = 0;
        @(negedge mclk);
        reqValid = 1'b1;
        reqAddr  = a;
        while (reqReady !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        @(negedge mclk);
        reqValid = 1'b0;
        reqAddr  = ~a;
        err      = respError;
        lat      = 1;
        while (respValid !== 1'b1 && lat < 5) begin
            @(negedge mclk);
            lat++;
        end
        err = err & respError;
    endtask : access
endmodule : adr_master_model

// ---- sim/adr_decoder_assertions.sv ----
// Checker on the decoder top ports, bound into the design
`timescale 1ns/1ps
module adr_decoder_assertions (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        clkEn,
    input wire logic        bootSelectPin,
    input wire logic        remapCmd,
    input wire logic        coupledMemWaitStateBit,
    input wire logic [1:0]  sramSplit,
    input wire logic        reqValid,
    input wire logic [31:0] reqAddr,
    input wire logic        reqReady,
    input wire logic        respValid,
    input wire logic        respError,
    input wire logic [5:0]  extChipSelect,
    input wire logic        dramChipSelect,
    input wire logic        periphSelect,
    input wire logic        romSelect,
    input wire logic        sramSelect,
    input wire logic [19:0] targetOffset,
    input wire logic [15:0] sramOffset,
    input wire logic        remapActive,
    input wire logic        bootFromRom,
    input wire logic        smcByteSelect,
    input wire logic        smcBus16,
    input wire logic        smcStrobeByCs
);
    // Frozen cycles are skipped: state legally stalls then
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst || !clkEn);
    logic       take;
    logic [3:0] bank;
    logic       zero;
    assign take = clkEn && reqValid && reqReady;
    assign bank = reqAddr[31:28];
    assign zero = reqAddr[31:20] == 12'h000;
    property p_one; $onehot0({extChipSelect, dramChipSelect,
        periphSelect, romSelect, sramSelect}); endproperty
    a_one: assert property (p_one) else $error("two selects");
    property p_ext; take && bank inside {[1:6]} |=>
        extChipSelect == (6'h01 << ($past(bank) - 4'h1)); endproperty
    a_ext: assert property (p_ext) else $error("ext select");
    property p_dram; take && bank == 4'h7 |=> dramChipSelect; endproperty
    a_dram: assert property (p_dram) else $error("dram select");
    property p_per; take && bank == 4'hF |=> periphSelect; endproperty
    a_per: assert property (p_per) else $error("periph select");
    property p_off; take |=> targetOffset == $past(reqAddr[19:0]);
    endproperty
    a_off: assert property (p_off) else $error("offset");
    property p_unused; take && bank inside {[8:14]} |=>
        respError && !respValid ##1 respError && respValid; endproperty
    a_unused: assert property (p_unused) else $error("no abort");
    property p_err; $rose(respError) |-> extChipSelect == 6'h00 &&
        !dramChipSelect && !periphSelect && !romSelect && !sramSelect
        ##1 respValid ##1 !respError; endproperty
    a_err: assert property (p_err) else $error("abort shape");
    property p_rom; take && reqAddr[31:20] == 12'h004 |=> romSelect;
    endproperty
    a_rom: assert property (p_rom) else $error("rom base");
    property p_boot; take && zero && bootFromRom && !remapActive
        |=> romSelect; endproperty
    a_boot: assert property (p_boot) else $error("rom alias");
    property p_bext; take && zero && !bootFromRom && !remapActive
        |=> extChipSelect == 6'h01; endproperty
    a_bext: assert property (p_bext) else $error("cs0 alias");
    property p_rmz; take && zero && remapActive
        |=> !romSelect && extChipSelect == 6'h00; endproperty
    a_rmz: assert property (p_rmz) else $error("remap alias");
    property p_keep; remapActive |=> remapActive; endproperty
    a_keep: assert property (p_keep) else $error("remap lost");
    c_abort: cover property ($rose(respError));
    c_remap: cover property ($rose(remapActive));
    c_sram:  cover property ($rose(sramSelect));
endmodule : adr_decoder_assertions

bind adr_decoder_top adr_decoder_assertions chk_u (.mclk, .rst, .clkEn,
    .bootSelectPin, .remapCmd, .coupledMemWaitStateBit, .sramSplit,
    .reqValid, .reqAddr, .reqReady, .respValid, .respError,
    .extChipSelect, .dramChipSelect, .periphSelect, .romSelect,
    .sramSelect, .targetOffset, .sramOffset, .remapActive, .bootFromRom,
    .smcByteSelect, .smcBus16, .smcStrobeByCs);

// ---- sim/tb_adr_decoder_top.sv ----
// Self-checking bench for the decoder top
`timescale 1ns/1ps
module tb_adr_decoder_top;
    logic        mclk = 1'b0, rst = 1'b1, bootPin = 1'b1, remapCmd = 1'b0;
    logic        waitBit = 1'b0, reqValid, reqReady, respValid, respError;
    logic [1:0]  split = 2'h0;
    logic [31:0] reqAddr;
    logic [5:0]  extCs;
    logic        dramCs, perSel, romSel, sramSel, remapOn, bootRom;
    logic [2:0]  static_memory_controller;
    logic [19:0] tgtOff;
    logic [15:0] sramOff;
    logic [9:0]  sel;
    logic        clkEn = 1'b1;
    int          failCount = 0;
    int          testsRun = 0;
    // 20 MHz bus clock
    always #25 mclk = ~mclk;
    adr_master_model mst_u (.mclk(mclk), .reqReady(reqReady),
        .respValid(respValid), .respError(respError),
        .reqValid(reqValid), .reqAddr(reqAddr));
    // Clock enable high but for one frozen cycle
    adr_decoder_top dut_u (.mclk(mclk), .rst(rst), .clkEn(clkEn),
        .bootSelectPin(bootPin), .remapCmd(remapCmd),
        .coupledMemWaitStateBit(waitBit), .sramSplit(split),
        .reqValid(reqValid), .reqAddr(reqAddr), .reqReady(reqReady),
        .respValid(respValid), .respError(respError),
        .extChipSelect(extCs), .dramChipSelect(dramCs),
        .periphSelect(perSel), .romSelect(romSel), .sramSelect(sramSel),
        .targetOffset(tgtOff), .sramOffset(sramOff),
        .remapActive(remapOn), .bootFromRom(bootRom),
        .smcByteSelect(static_memory_controller[2]), .smcBus16(static_memory_controller[1]), .smcStrobeByCs(static_memory_controller[0]));
    task automatic cmp(input string what, input logic [19:0] exp,
                       input logic [19:0] got);
        testsRun++;
        if (got !== exp) begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // Select vector: ext[5:0], dram, periph, rom, sram
    task automatic chk(input logic [31:0] a, input logic [9:0] s,
                       input int lat, input logic err);
        int   l;
        logic e;
        mst_u.access(a, l, e);
        cmp("select", {10'h0, s},
            {10'h0, extCs, dramCs, perSel, romSel, sramSel});
        cmp("latency", 20'(lat), 20'(l));
        cmp("error", {19'h0, err}, {19'h0, e});
        $display("test at %h done", a);
    endtask : chk
    // Reset of five cycles; boot pin settled well before release
    task automatic doReset(input logic pin);
        rst     = 1'b1;
        bootPin = pin;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        @(negedge mclk);
    endtask : doReset
    task automatic giveVerdict;
        $display("comparisons %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : giveVerdict
    // Watchdog well beyond the expected run
    initial begin
        #(50 * 5000);
        failCount++;
        giveVerdict;
    end
    initial begin
        doReset(1'b1);
        cmp("bootRom", 20'h1, {19'h0, bootRom});
        cmp("smc", 20'h0, {17'h0, static_memory_controller});
        for (int b = 1; b < 16; b++) begin
            sel = b < 7 ? 10'h010 << (b - 1) : b == 7 ? 10'h008 :
                  b == 15 ? 10'h004 : 10'h000;
            chk({b[3:0], 28'h0ABCDE4}, sel,
                sel == 0 ? 2 : 1, sel == 0);
            if (sel != 0) cmp("offset", 20'hBCDE4, tgtOff);
        end
        chk(32'h0040_0010, 10'h002, 1, 1'b0);
        chk(32'h0000_0010, 10'h002, 1, 1'b0);
        chk(32'h0030_FFFC, 10'h001, 1, 1'b0);
        cmp("sramOff", 20'h0FFFC, {4'h0, sramOff});
        chk(32'h0031_0000, 10'h000, 2, 1'b1);
        chk(32'h0010_0000, 10'h000, 2, 1'b1);
        chk(32'h0050_0000, 10'h000, 2, 1'b1);
        split   = 2'h2;
        waitBit = 1'b1;
        chk(32'h0010_7FFC, 10'h001, 2, 1'b0);
        cmp("sramOff", 20'h07FFC, {4'h0, sramOff});
        chk(32'h0020_0004, 10'h001, 2, 1'b0);
        cmp("sramOff", 20'h08004, {4'h0, sramOff});
        chk(32'h0010_8000, 10'h000, 2, 1'b1);
        waitBit = 1'b0;
        chk(32'h0020_0004, 10'h001, 1, 1'b0);
        split = 2'h1;
        chk(32'h0020_FFF0, 10'h001, 1, 1'b0);
        cmp("sramOff", 20'h0FFF0, {4'h0, sramOff});
        chk(32'h0030_0000, 10'h000, 2, 1'b1);
        split    = 2'h0;
        remapCmd = 1'b1;
        @(negedge mclk);
        remapCmd = 1'b0;
        chk(32'h0000_0020, 10'h001, 1, 1'b0);
        cmp("sramOff", 20'h00020, {4'h0, sramOff});
        chk(32'h0040_0000, 10'h002, 1, 1'b0);
        chk(32'h0030_0020, 10'h001, 1, 1'b0);
        cmp("remap", 20'h1, {19'h0, remapOn});
        split = 2'h1;
        chk(32'h0000_0000, 10'h000, 2, 1'b1);
        split = 2'h0;
        doReset(1'b0);
        cmp("remap", 20'h0, {19'h0, remapOn});
        cmp("bootRom", 20'h0, {19'h0, bootRom});
        cmp("smc", 20'h7, {17'h0, static_memory_controller});
        chk(32'h0000_0100, 10'h010, 1, 1'b0);
        chk(32'h0030_0000, 10'h001, 1, 1'b0);
        clkEn    = 1'b0;
        remapCmd = 1'b1;
        @(negedge mclk);
        clkEn    = 1'b1;
        remapCmd = 1'b0;
        cmp("frozen", 20'h0, {19'h0, remapOn});
        giveVerdict;
    end
endmodule : tb_adr_decoder_top
